// ===== logic/tgt_cmp_pkg.sv
package tgt_cmp_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] REG_GENERAL_CONFIG = 8'h00;
   localparam logic [7:0] REG_REFERENCE_CONFIG = 8'h01;
   localparam logic [7:0] REG_COMPARE_VALUE = 8'h32;
   localparam logic [7:0] REG_CIRCULAR_RANGE = 8'h36;
   localparam logic [7:0] REG_ACTUAL_POSITION = 8'h21;
   localparam logic [7:0] REG_TARGET_POSITION = 8'h37;
   localparam logic [7:0] REG_STATUS = 8'h0F;
   localparam logic [7:0] REG_EVENTS = 8'h0E;
   localparam logic [7:0] REG_HOME_POSITION = 8'h35;
   localparam logic [7:0] REG_POSITION_LATCH = 8'h38;
   localparam logic [7:0] REG_ENCODER_LATCH = 8'h39;
   // general_config fields
   localparam int GC_PULL_DRIVE_ENABLE = 5;
   localparam int GC_WIRED_AND_SELECT = 6;
   localparam int GC_REV_AS_LATCH = 7;
   localparam int GC_INVERT_ARRIVAL = 16;
   // reference_config fields
   localparam int RC_CLEAR_AT_TARGET = 10;
   localparam int RC_CIRCULAR_ENABLE = 11;
   localparam int RC_OUT_SRC_LO = 12;
   localparam int RC_CMP_SOURCE = 14;
   localparam int RC_CMP_MODE_LO = 15;
   // status / event bit positions
   localparam int ST_TARGET_REACHED = 0;
   localparam int ST_COMPARE_MATCH = 1;
   localparam int ST_VELOCITY_REACHED = 2;
   localparam int ST_ENCODER_FAIL = 3;
   // reset value, source and compare-mode codes, unit step
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] SRC_TARGET = 2'h0;
   localparam logic [1:0] SRC_VELOCITY = 2'h1;
   localparam logic [1:0] SRC_ENC_FAIL = 2'h2;
   localparam logic [1:0] SRC_COMPARE = 2'h3;
   localparam logic [1:0] CMP_VALUE = 2'h0;
   localparam logic [1:0] CMP_HOME = 2'h1;
   localparam logic [1:0] CMP_LATCH = 2'h2;
   localparam logic [1:0] CMP_REVS = 2'h3;
   localparam logic [31:0] ONE_STEP = 32'h0000_0001;
   typedef enum logic [1:0] {
      MOTION_IDLE,
      MOTION_RUN,
      MOTION_DONE
   } motion_state_t;
endpackage

// ===== logic/arrival_pin_driver.sv
`timescale 1ns/100ps
// shared-line drive of the arrival pin: strong and weak legs as separate enables
module arrival_pin_driver
   import tgt_cmp_pkg::*;
(
   // control
   input wire logic active,
   input wire logic pull_drive_enable,
   input wire logic wired_and_select,
   input wire logic invert_polarity,
   // pin
   output logic pin_out,
   output logic pin_oe,
   output logic pin_weak
);
   logic level;  // electrical level for the current state
   always_comb begin
      level = active ^ invert_polarity;
      pin_out = level;
      if (!pull_drive_enable) begin
         // plain push-pull until shared mode is enabled
         pin_oe = 1'b1;
         pin_weak = 1'b0;
      end else if (!wired_and_select) begin
         // wired-or: active strong, inactive weak
         pin_oe = 1'b1;
         pin_weak = !active;
      end else begin
         // wired-and: inactive strong, active weak
         pin_oe = 1'b1;
         pin_weak = active;
      end
   end
endmodule // arrival_pin_driver

// ===== logic/target_compare.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
// Notes on behaviour
// - shared drive only after pull enable set
// - wired-or: inactive weak, active strong
// - wired-and: inactive strong, active weak
// - two-bit field selects forwarded flag
// - target flag when actual equals target
// - comparator always runs, flag and event
// - source 0 compares internal actual position
// - source 1 compares encoder position
// - encoder compare value in microsteps
// - encoder crossing latches event without flag
// - mode field picks comparison reference
// - without repetition, target ends ramp
// - clear-at-target zeroes position, restarts ramp unless target is zero
// - target rewritable, zero on every match
// - circular wrap loads opposite limit
// - range write then circular enable
// - invert bit makes arrival active low
// - range spans minus range to range-1
module target_compare
   import tgt_cmp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // motion inputs
   input wire logic step_pulse,
   input wire logic step_dir,
   input wire logic positioning_mode,
   input wire logic velocity_reached,
   input wire logic encoder_fail,
   input wire logic [31:0] encoder_position,
   // motion outputs
   output logic ramp_active,
   // arrival pin
   output logic arrival_out,
   output logic arrival_oe,
   output logic arrival_weak
);
   // complete block state
   typedef struct packed {
      logic [31:0] general_config;
      logic [31:0] reference_config;
      logic [31:0] compare_value;
      logic [31:0] circular_range;
      logic [31:0] actual_position;
      logic [31:0] target_position;
      logic [31:0] home_position;
      logic [31:0] position_latch;
      logic [31:0] encoder_latch;
      logic [31:0] rev_count;
      logic [31:0] prev_encoder;
      logic [3:0] events;
      logic [31:0] rdata;
      motion_state_t motion;
   } state_t;

   state_t cur;       // registered state
   state_t next_cur;  // next state
   logic [3:0] flags;  // live status flags
   logic target_hit;  // actual equals target
   logic cmp_hit;     // selected comparison equal
   logic cmp_cross;   // encoder passed compare value
   logic [31:0] cmp_lhs;  // selected position side
   logic [31:0] cmp_rhs;  // selected reference side
   logic circ_on;     // circular mode in force
   logic [31:0] range_hi;  // range minus one
   logic [31:0] range_lo;  // negative range
   logic arrival_active;  // forwarded flag

   // signed strict crossing test between two samples
   function automatic logic crossed(input logic [31:0] a, input logic [31:0] b, input logic [31:0] v);
      crossed = (($signed(a) < $signed(v)) && ($signed(b) > $signed(v)))
         || (($signed(a) > $signed(v)) && ($signed(b) < $signed(v)));
   endfunction

   // comparator selection and flags, no start command needed
   always_comb begin
      target_hit = (cur.actual_position == cur.target_position);
      cmp_lhs = cur.actual_position;
      cmp_rhs = cur.compare_value;
      if (cur.reference_config[RC_CMP_SOURCE]) begin
         // encoder position is already in microsteps, so compare value is too
         cmp_lhs = encoder_position;
      end
      unique case (cur.reference_config[RC_CMP_MODE_LO +: 2])
         CMP_VALUE: cmp_rhs = cur.compare_value;
         CMP_HOME: cmp_rhs = cur.home_position;
         CMP_LATCH: cmp_rhs = cur.reference_config[RC_CMP_SOURCE] ? cur.encoder_latch : cur.position_latch;
         CMP_REVS: begin
            cmp_lhs = cur.rev_count;
            cmp_rhs = cur.compare_value;
         end
      endcase
      cmp_hit = (cmp_lhs == cmp_rhs);
      // a jump over the value in encoder base is an event only
      cmp_cross = cur.reference_config[RC_CMP_SOURCE]
         && (cur.reference_config[RC_CMP_MODE_LO +: 2] != CMP_REVS)
         && crossed(cur.prev_encoder, encoder_position, cmp_rhs);
      flags = '0;
      flags[ST_TARGET_REACHED] = target_hit;
      flags[ST_COMPARE_MATCH] = cmp_hit;
      flags[ST_VELOCITY_REACHED] = velocity_reached;
      flags[ST_ENCODER_FAIL] = encoder_fail;
      unique case (cur.reference_config[RC_OUT_SRC_LO +: 2])
         SRC_TARGET: arrival_active = target_hit;
         SRC_VELOCITY: arrival_active = velocity_reached;
         SRC_ENC_FAIL: arrival_active = encoder_fail;
         SRC_COMPARE: arrival_active = cmp_hit;
      endcase
      circ_on = cur.reference_config[RC_CIRCULAR_ENABLE] && (cur.circular_range != RESET_WORD);
      range_hi = cur.circular_range - ONE_STEP;
      range_lo = RESET_WORD - cur.circular_range;
   end

   // next-state logic: registers, position, events
   always_comb begin
      next_cur = cur;
      next_cur.prev_encoder = encoder_position;
      next_cur.rdata = RESET_WORD;
      // read side: events clear on read, set wins below
      if (reg_rd) begin
         unique case (reg_addr)
            REG_GENERAL_CONFIG: next_cur.rdata = cur.general_config;
            REG_REFERENCE_CONFIG: next_cur.rdata = cur.reference_config;
            REG_COMPARE_VALUE: next_cur.rdata = cur.compare_value;
            // range is write-only; this address shows a latch or revolutions
            REG_CIRCULAR_RANGE: next_cur.rdata = cur.general_config[GC_REV_AS_LATCH]
               ? cur.rev_count : cur.position_latch;
            REG_ACTUAL_POSITION: next_cur.rdata = cur.actual_position;
            REG_TARGET_POSITION: next_cur.rdata = cur.target_position;
            REG_HOME_POSITION: next_cur.rdata = cur.home_position;
            REG_ENCODER_LATCH: next_cur.rdata = cur.encoder_latch;
            REG_STATUS: next_cur.rdata = {28'h0, flags};
            REG_EVENTS: begin
               next_cur.rdata = {28'h0, cur.events};
               next_cur.events = '0;
            end
            default: next_cur.rdata = RESET_WORD;
         endcase
      end
      // write side
      if (reg_wr) begin
         unique case (reg_addr)
            REG_GENERAL_CONFIG: next_cur.general_config = reg_wdata;
            REG_REFERENCE_CONFIG: next_cur.reference_config = reg_wdata;
            REG_COMPARE_VALUE: next_cur.compare_value = reg_wdata;
            REG_CIRCULAR_RANGE: next_cur.circular_range = reg_wdata;
            REG_ACTUAL_POSITION: next_cur.actual_position = reg_wdata;
            REG_TARGET_POSITION: next_cur.target_position = reg_wdata;
            REG_HOME_POSITION: next_cur.home_position = reg_wdata;
            REG_POSITION_LATCH: next_cur.position_latch = reg_wdata;
            REG_ENCODER_LATCH: next_cur.encoder_latch = reg_wdata;
            default: ;
         endcase
      end
      // motion sequence; steps move the position only while a ramp runs
      unique case (cur.motion)
         MOTION_IDLE: begin
            if (positioning_mode && !target_hit) begin
               next_cur.motion = MOTION_RUN;
            end
         end
         MOTION_RUN: begin
            if (!positioning_mode) begin
               next_cur.motion = MOTION_IDLE;
            end else if (target_hit) begin
               if (cur.reference_config[RC_CLEAR_AT_TARGET]) begin
                  // repeat from zero on every match unless the target is zero, even after target rewrites
                  next_cur.actual_position = RESET_WORD;
                  next_cur.motion = (cur.target_position != RESET_WORD) ? MOTION_RUN : MOTION_DONE;
               end else begin
                  next_cur.motion = MOTION_DONE;
               end
            end else if (step_pulse) begin
               // circular wrap at either end; position must start inside range
               if (circ_on && step_dir && cur.actual_position == range_hi) begin
                  next_cur.actual_position = range_lo;
                  next_cur.rev_count = cur.rev_count + ONE_STEP;
               end else if (circ_on && !step_dir && cur.actual_position == range_lo) begin
                  next_cur.actual_position = range_hi;
                  next_cur.rev_count = cur.rev_count - ONE_STEP;
               end else begin
                  next_cur.actual_position = step_dir ? cur.actual_position + ONE_STEP
                     : cur.actual_position - ONE_STEP;
               end
            end
         end
         MOTION_DONE: begin
            // restart only after a new target or leaving positioning
            if (!positioning_mode || !target_hit) begin
               next_cur.motion = MOTION_IDLE;
            end
         end
      endcase
      if (!circ_on) begin
         next_cur.rev_count = RESET_WORD;
      end
      // event latching; set wins over a clearing read
      if (target_hit) begin
         next_cur.events[ST_TARGET_REACHED] = 1'b1;
      end
      if (cmp_hit || cmp_cross) begin
         next_cur.events[ST_COMPARE_MATCH] = 1'b1;
      end
      if (velocity_reached) begin
         next_cur.events[ST_VELOCITY_REACHED] = 1'b1;
      end
      if (encoder_fail) begin
         next_cur.events[ST_ENCODER_FAIL] = 1'b1;
      end
   end

   // state register with synchronous reset and clock enable
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cur <= '0;
         cur.motion <= MOTION_IDLE;
         // crossing detector starts at the live encoder value, so no false pass after reset
         cur.prev_encoder <= encoder_position;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   assign reg_rdata = cur.rdata;
   assign ramp_active = (cur.motion == MOTION_RUN);

   // pin drive stage
   arrival_pin_driver u_pin (
      .active(arrival_active),
      .pull_drive_enable(cur.general_config[GC_PULL_DRIVE_ENABLE]),
      .wired_and_select(cur.general_config[GC_WIRED_AND_SELECT]),
      .invert_polarity(cur.general_config[GC_INVERT_ARRIVAL]),
      .pin_out(arrival_out),
      .pin_oe(arrival_oe),
      .pin_weak(arrival_weak)
   );

   // checks
   property p_target_flag;
      @(posedge core_clk) disable iff (srst)
      (clk_en && reg_rd && reg_addr == REG_STATUS)
         |=> (reg_rdata[ST_TARGET_REACHED] == $past(target_hit));
   endproperty
   a_target_flag: assert property (p_target_flag) else $error("target flag missing");

   property p_event_latch;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cmp_hit) |=> cur.events[ST_COMPARE_MATCH];
   endproperty
   a_event_latch: assert property (p_event_latch) else $error("compare event not latched");

   property p_src0;
      @(posedge core_clk) disable iff (srst)
      (!cur.reference_config[RC_CMP_SOURCE] && cur.reference_config[RC_CMP_MODE_LO +: 2] == CMP_VALUE)
         |-> (cmp_hit == (cur.actual_position == cur.compare_value));
   endproperty
   a_src0: assert property (p_src0) else $error("internal compare wrong");

   property p_src1;
      @(posedge core_clk) disable iff (srst)
      (cur.reference_config[RC_CMP_SOURCE] && cur.reference_config[RC_CMP_MODE_LO +: 2] == CMP_VALUE)
         |-> (cmp_hit == (encoder_position == cur.compare_value));
   endproperty
   a_src1: assert property (p_src1) else $error("encoder compare wrong");

   property p_cross;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cmp_cross) |=> cur.events[ST_COMPARE_MATCH];
   endproperty
   a_cross: assert property (p_cross) else $error("crossing not latched");

   property p_clear_target;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cur.motion == MOTION_RUN && positioning_mode && target_hit
         && cur.reference_config[RC_CLEAR_AT_TARGET]) |=> (cur.actual_position == RESET_WORD);
   endproperty
   a_clear_target: assert property (p_clear_target) else $error("position not cleared");

   property p_stop;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cur.motion == MOTION_RUN && positioning_mode && target_hit
         && !cur.reference_config[RC_CLEAR_AT_TARGET]) |=> (cur.motion == MOTION_DONE);
   endproperty
   a_stop: assert property (p_stop) else $error("ramp not ended");

   property p_wrap;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cur.motion == MOTION_RUN && positioning_mode && !target_hit && step_pulse && step_dir
         && circ_on && cur.actual_position == range_hi && !reg_wr) |=> (cur.actual_position == $past(range_lo));
   endproperty
   a_wrap: assert property (p_wrap) else $error("circular wrap wrong");

   property p_polarity;
      @(posedge core_clk) disable iff (srst)
      arrival_out == (arrival_active ^ cur.general_config[GC_INVERT_ARRIVAL]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("arrival polarity wrong");

   property p_target_event;
      @(posedge core_clk) disable iff (srst)
      (clk_en && target_hit) |=> cur.events[ST_TARGET_REACHED];
   endproperty
   a_target_event: assert property (p_target_event) else $error("target event not latched");

   // a clearing read must not lose a match of the same cycle, but must clear otherwise
   property p_read_clear;
      @(posedge core_clk) disable iff (srst)
      (clk_en && reg_rd && reg_addr == REG_EVENTS && !cmp_hit && !cmp_cross)
         |=> !cur.events[ST_COMPARE_MATCH];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("compare event not cleared by read");

   property p_repeat;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cur.motion == MOTION_RUN && positioning_mode && target_hit
         && cur.reference_config[RC_CLEAR_AT_TARGET] && cur.target_position != RESET_WORD)
         |=> (cur.motion == MOTION_RUN);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repetitive ramp not restarted");

   property p_wrap_down;
      @(posedge core_clk) disable iff (srst)
      (clk_en && cur.motion == MOTION_RUN && positioning_mode && !target_hit && step_pulse && !step_dir
         && circ_on && cur.actual_position == range_lo) |=> (cur.actual_position == $past(range_hi));
   endproperty
   a_wrap_down: assert property (p_wrap_down) else $error("circular wrap down wrong");

   // clock enable low holds every bit of state
   property p_freeze;
      @(posedge core_clk) disable iff (srst)
      (!clk_en) |=> (cur == $past(cur));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (srst)
      (clk_en && !reg_rd) |=> (reg_rdata == RESET_WORD);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule // target_compare

// ===== sim/shared_line_model.sv
`timescale 1ns/100ps
// other controllers on the shared arrival line, folded into one peer, plus the wire itself
module shared_line_model (
   // our pin legs
   input wire logic own_level,
   input wire logic own_oe,
   input wire logic own_weak,
   // peer state and line setup
   input wire logic peer_active,
   input wire logic and_mode,
   input wire logic inverted,
   // resolved wire
   output logic line
);
   logic peer_strong; // peer drives hard
   logic peer_level; // level the peer puts out
   logic own_strong; // our pin drives hard
   // peer legs: or-mode is hard only when active, and-mode hard only when inactive
   assign peer_strong = and_mode ? !peer_active : peer_active;
   assign peer_level = peer_active ^ inverted;
   assign own_strong = own_oe & !own_weak;
   // strong beats weak; two strong legs that disagree make an unknown, never a guess
   always_comb begin
      if (own_strong && peer_strong) begin
         line = (own_level == peer_level) ? own_level : 1'bx;
      end else if (own_strong) begin
         line = own_level;
      end else if (peer_strong) begin
         line = peer_level;
      end else begin
         // both weak: the two weak legs agree on the inactive or active level
         line = own_oe ? own_level : peer_level;
      end
   end
endmodule // shared_line_model

// ===== sim/tb_target_compare.sv
`timescale 1ns/100ps
// self-checking bench for arrival pin and position compare
module tb_target_compare;
   import tgt_cmp_pkg::*;
   // clock, reset, register port
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1; // high except in the freeze scenario
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   // motion side
   logic step_pulse = 1'b0;
   logic step_dir = 1'b1;
   logic positioning_mode = 1'b0;
   logic velocity_reached = 1'b0;
   logic encoder_fail = 1'b0;
   logic [31:0] encoder_position = 32'h0;
   logic ramp_active, arrival_out, arrival_oe, arrival_weak;
   // shared line
   logic peer_active = 1'b0;
   logic and_mode = 1'b0;
   logic inverted = 1'b0;
   logic line;
   // bookkeeping
   int err_total = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h0000_CC5D;
   logic [31:0] rv, exp_v;
   logic act;
   logic [7:0] refs [4] = '{REG_COMPARE_VALUE, REG_HOME_POSITION, REG_POSITION_LATCH, REG_COMPARE_VALUE};

   initial forever #5 core_clk = ~core_clk;

   target_compare target_compare_i (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_pulse(step_pulse),
      .step_dir(step_dir), .positioning_mode(positioning_mode), .velocity_reached(velocity_reached),
      .encoder_fail(encoder_fail), .encoder_position(encoder_position), .ramp_active(ramp_active),
      .arrival_out(arrival_out), .arrival_oe(arrival_oe), .arrival_weak(arrival_weak));
   shared_line_model shared_line_model_i (.own_level(arrival_out), .own_oe(arrival_oe), .own_weak(arrival_weak),
      .peer_active(peer_active), .and_mode(and_mode), .inverted(inverted), .line(line));

   // xorshift source, fixed start so runs repeat
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // flag the pin should forward for a source code
   function logic fwd(input logic [1:0] src, input logic tgt, input logic cmp, input logic vel, input logic enc);
      return (src == SRC_TARGET) ? tgt : (src == SRC_VELOCITY) ? vel : (src == SRC_ENC_FAIL) ? enc : cmp;
   endfunction
   // one comparison
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle write strobe
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // sixteen-cycle reset, motion stopped
   task do_reset();
      @(posedge core_clk);
      srst <= 1'b1;
      positioning_mode <= 1'b0;
      step_pulse <= 1'b0;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
   endtask
   // positioning with a step every cycle, long enough for any small target
   task run(input logic dir);
      @(posedge core_clk);
      step_dir <= dir;
      positioning_mode <= 1'b1;
      step_pulse <= 1'b1;
      repeat (24) @(posedge core_clk);
      step_pulse <= 1'b0;
      #1;
   endtask
   // single end of run
   task tally_and_finish();
      $display("counts: %0d mismatches in %0d checks", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      do_reset();
      // reset words and an unmapped index
      rd(REG_GENERAL_CONFIG, rv);
      check(rv, RESET_WORD);
      rd(REG_REFERENCE_CONFIG, rv);
      check(rv, RESET_WORD);
      rd(8'hFF, rv);
      check(rv, 32'h0);
      repeat (4) begin
         exp_v = xs();
         wr(REG_COMPARE_VALUE, exp_v);
         rd(REG_COMPARE_VALUE, rv);
         check(rv, exp_v);
      end
      // every source, polarity, drive mode; peer random
      wr(REG_COMPARE_VALUE, 32'h0000_0009);
      for (int k = 0; k < 32; k++) begin
         rv = xs();
         @(posedge core_clk);
         velocity_reached <= rv[0];
         encoder_fail <= rv[1];
         peer_active <= rv[2];
         and_mode <= k[4];
         inverted <= k[0];
         wr(REG_GENERAL_CONFIG, {15'h0, k[0], 9'h0, k[4], k[3], 5'h0});
         wr(REG_REFERENCE_CONFIG, {18'h0, k[2:1], 12'h0});
         repeat (2) @(posedge core_clk);
         #1 act = fwd(k[2:1], 1'b1, 1'b0, rv[0], rv[1]);
         check(arrival_out, act ^ k[0]);
         check(arrival_oe, 1'b1);
         check(arrival_weak, k[3] & (k[4] ? act : !act));
         if (k[3]) check(line, (k[4] ? (act & rv[2]) : (act | rv[2])) ^ k[0]);
      end
      // each compare mode against its own reference
      do_reset();
      for (int m = 0; m < 4; m++) begin
         wr(REG_COMPARE_VALUE, 32'h0000_0007);
         wr(REG_HOME_POSITION, 32'h0000_0007);
         wr(REG_POSITION_LATCH, 32'h0000_0007);
         wr(REG_REFERENCE_CONFIG, {15'h0, m[1:0], 15'h0});
         rd(REG_STATUS, rv);
         check(rv[ST_COMPARE_MATCH], 1'b0);
         wr(refs[m], 32'h0);
         rd(REG_STATUS, rv);
         check(rv[ST_COMPARE_MATCH], 1'b1);
      end
      // positioning run that passes the compare value
      do_reset();
      wr(REG_COMPARE_VALUE, 32'h0000_0003);
      wr(REG_TARGET_POSITION, 32'h0000_0005);
      rd(REG_EVENTS, rv);
      run(1'b1);
      check(ramp_active, 1'b0);
      rd(REG_ACTUAL_POSITION, rv);
      check(rv, 32'h0000_0005);
      rd(REG_STATUS, rv);
      check(rv[1:0], 2'h1);
      rd(REG_EVENTS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b1);
      rd(REG_EVENTS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b0);
      // repetitive motion, target rewritten mid-run to a new value
      do_reset();
      wr(REG_REFERENCE_CONFIG, 32'h0000_0400);
      wr(REG_TARGET_POSITION, 32'h0000_0004);
      run(1'b1);
      check(ramp_active, 1'b1);
      rd(REG_ACTUAL_POSITION, rv);
      check(rv < 32'h4, 1'b1);
      exp_v = rv + 32'h2;
      wr(REG_TARGET_POSITION, exp_v);
      run(1'b1);
      check(ramp_active, 1'b1);
      rd(REG_ACTUAL_POSITION, rv);
      check(rv < exp_v, 1'b1);
      // circular wrap both ways, range four, then the revolution count
      for (int d = 0; d < 2; d++) begin
         do_reset();
         wr(REG_CIRCULAR_RANGE, 32'h0000_0004);
         wr(REG_REFERENCE_CONFIG, 32'h0000_0800);
         exp_v = d ? 32'hFFFF_FFFC : 32'h0000_0003;
         wr(REG_TARGET_POSITION, exp_v);
         run(d[0]);
         rd(REG_ACTUAL_POSITION, rv);
         check(rv, exp_v);
         rd(REG_CIRCULAR_RANGE, rv);
         check(rv, 32'h0);
         wr(REG_GENERAL_CONFIG, 32'h0000_0080);
         rd(REG_CIRCULAR_RANGE, rv);
         check(rv, d ? 32'h0000_0001 : 32'hFFFF_FFFF);
      end
      // clock enable low freezes a pending ramp and its steps
      do_reset();
      wr(REG_TARGET_POSITION, 32'h0000_0040);
      @(posedge core_clk);
      clk_en <= 1'b0;
      positioning_mode <= 1'b1;
      step_pulse <= 1'b1;
      repeat (8) @(posedge core_clk);
      clk_en <= 1'b1;
      step_pulse <= 1'b0;
      #1;
      check(ramp_active, 1'b0);
      rd(REG_ACTUAL_POSITION, rv);
      check(rv, 32'h0);
      // encoder as comparison base, then a jump past it
      do_reset();
      wr(REG_REFERENCE_CONFIG, 32'h0000_4000);
      wr(REG_COMPARE_VALUE, 32'h0000_0064);
      @(posedge core_clk);
      encoder_position <= 32'h0000_0064;
      rd(REG_STATUS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b1);
      @(posedge core_clk);
      encoder_position <= 32'h0000_005A;
      rd(REG_EVENTS, rv);
      rd(REG_EVENTS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b0);
      @(posedge core_clk);
      encoder_position <= 32'h0000_006E;
      rd(REG_STATUS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b0);
      rd(REG_EVENTS, rv);
      check(rv[ST_COMPARE_MATCH], 1'b1);
      tally_and_finish();
   end
endmodule // tb_target_compare
